/* File: inc/cbr_pkg.sv */
// What this block does
// - Only the four rates 125 kbit/s, 250 kbit/s, 500 kbit/s and 1 Mbit/s ever reach the CAN controller.
// - The start-up rate is decided once after power-on and the chosen value is handed on for non-volatile storage.
// - A valid setup table with its override flag set supplies the rate code that is applied.
// - The setup table's rate code names one of the four rates or the firmware default, which means 500 kbit/s.
// - A valid table with the override flag clear, or an invalid table, applies the retained rate if one exists.
// - An invalid table with no retained rate falls back to the firmware default of 500 kbit/s.
// - A rate set by a network master's layer-setting command after the power-on decision becomes the retained rate and is applied; one before it is ignored.
package cbr_pkg;

    // Two-bit rate codes seen by the CAN controller.
    localparam logic [1:0] CBR_RATE_125K = 2'h0;
    localparam logic [1:0] CBR_RATE_250K = 2'h1;
    localparam logic [1:0] CBR_RATE_500K = 2'h2;
    localparam logic [1:0] CBR_RATE_1M = 2'h3;
    localparam logic [1:0] CBR_RATE_FW_DEFAULT = CBR_RATE_500K;

    // Setup table rate field: codes 0 to 3 pick a rate, this one picks the firmware default.
    localparam logic [2:0] CBR_CFG_FW_DEFAULT = 3'h4;

    // Register byte offsets.
    localparam logic [7:0] CBR_OFF_STATUS = 8'h00;
    localparam logic [7:0] CBR_OFF_KEPT = 8'h04;

    // Status register fields.
    localparam int CBR_ST_RATE_LSB = 0;
    localparam int CBR_ST_READY_BIT = 2;
    localparam int CBR_ST_SRC_LSB = 3;
    localparam int CBR_ST_KEPTV_BIT = 6;

    // Retained rate register fields.
    localparam int CBR_KEPT_CODE_LSB = 0;
    localparam int CBR_KEPT_VALID_BIT = 2;

    // Reset values.
    localparam logic [1:0] CBR_RST_RATE = CBR_RATE_FW_DEFAULT;
    localparam logic [31:0] CBR_RST_WORD = 32'h0000_0000;

    // AHB encodings.
    localparam logic [1:0] CBR_HTRANS_NONSEQ = 2'h2;
    localparam logic CBR_HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {
        CBR_SRC_NONE,
        CBR_SRC_SETUP,
        CBR_SRC_KEPT,
        CBR_SRC_DEFAULT,
        CBR_SRC_LSS
    } cbr_src_type;

    typedef enum logic [1:0] {
        CBR_ST_WAIT,
        CBR_ST_EVAL,
        CBR_ST_RUN
    } cbr_state_type;

    // Maps a setup table rate field onto a legal two-bit rate.
    function automatic logic [1:0] cbr_resolve(input logic [2:0] cfgCode);
        logic [1:0] rate;
        rate = CBR_RATE_FW_DEFAULT;
        if (cfgCode < CBR_CFG_FW_DEFAULT) begin
            rate = cfgCode[1:0];
        end
        return rate;
    endfunction

endpackage

/* File: hw/cbr_rate_code.sv */
`timescale 1ns/100ps
`default_nettype none
module cbr_rate_code
    import cbr_pkg::*;
(
    // Setup table
    input wire logic cfgValid,
    input wire logic cfgOverride,
    input wire logic [2:0] cfgCode,
    // Retained rate
    input wire logic keptValid,
    input wire logic [1:0] keptCode,
    // Decision
    output logic [1:0] rate,
    output var cbr_src_type source
);

    always_comb begin
        if (cfgValid && cfgOverride) begin
            rate = cbr_resolve(cfgCode);
            source = CBR_SRC_SETUP;
        end else if (keptValid) begin
            rate = keptCode;
            source = CBR_SRC_KEPT;
        end else begin
            rate = CBR_RATE_FW_DEFAULT;
            source = CBR_SRC_DEFAULT;
        end
    end

endmodule
`default_nettype wire

/* File: hw/cbr_rate_select.sv */
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cbr_rate_select
    import cbr_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Setup table from non-volatile memory
    input wire logic cfgValid,
    input wire logic cfgOverride,
    input wire logic [2:0] cfgCode,
    // Retained rate from non-volatile memory
    input wire logic keptInValid,
    input wire logic [1:0] keptInCode,
    // Layer-setting update from the protocol engine
    input wire logic lssStrobe,
    input wire logic [1:0] lssCode,
    // CAN controller
    output logic [1:0] canRate,
    output logic rateReady,
    // Non-volatile save request
    output logic saveStrobe,
    output logic [1:0] saveCode,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    cbr_state_type state;
    cbr_state_type next_state;
    cbr_src_type source;
    cbr_src_type next_source;
    logic [1:0] next_canRate;
    logic next_rateReady;
    logic next_saveStrobe;
    logic [1:0] next_saveCode;
    logic keptValid;
    logic next_keptValid;
    logic [1:0] keptCode;
    logic [1:0] next_keptCode;
    logic [1:0] pickRate;
    cbr_src_type pickSource;

    logic wrPend;
    logic next_wrPend;
    logic [7:0] wrAddr;
    logic [7:0] next_wrAddr;
    logic [31:0] next_hrdata;
    logic next_hreadyout;
    logic next_hresp;
    logic addrPhase;
    logic swWrite;
    logic [31:0] statusWord;
    logic [31:0] keptWord;

    cbr_rate_code u_pick (
        .cfgValid(cfgValid),
        .cfgOverride(cfgOverride),
        .cfgCode(cfgCode),
        .keptValid(keptValid),
        .keptCode(keptCode),
        .rate(pickRate),
        .source(pickSource)
    );

    // Register views.
    always_comb begin
        statusWord = CBR_RST_WORD;
        statusWord[CBR_ST_RATE_LSB +: 2] = canRate;
        statusWord[CBR_ST_READY_BIT] = rateReady;
        statusWord[CBR_ST_SRC_LSB +: 3] = source;
        statusWord[CBR_ST_KEPTV_BIT] = keptValid;
        keptWord = CBR_RST_WORD;
        keptWord[CBR_KEPT_CODE_LSB +: 2] = keptCode;
        keptWord[CBR_KEPT_VALID_BIT] = keptValid;
    end

    // Bus slave: zero wait states, so the address is decoded in the address phase
    // and read data is registered to stand through the data phase.
    assign addrPhase = hsel && hready && (htrans == CBR_HTRANS_NONSEQ);
    // A software write to the retained rate acts like a layer-setting update, so it
    // is only honoured once the power-on decision has been taken.
    assign swWrite = wrPend && (wrAddr == CBR_OFF_KEPT);

    always_comb begin
        next_wrPend = addrPhase && hwrite;
        next_wrAddr = wrAddr;
        next_hrdata = hrdata;
        // The slave never stretches a transfer, so ready stands high once out of reset.
        next_hreadyout = 1'b1;
        next_hresp = CBR_HRESP_OKAY;
        if (addrPhase) begin
            next_wrAddr = haddr[7:0];
            if (!hwrite) begin
                if (haddr[31:0] == {24'h00_0000, CBR_OFF_STATUS}) begin
                    next_hrdata = statusWord;
                end else if (haddr[31:0] == {24'h00_0000, CBR_OFF_KEPT}) begin
                    next_hrdata = keptWord;
                end else begin
                    next_hrdata = CBR_RST_WORD;
                end
            end
        end
        if (addrPhase && haddr[31:8] != 24'h00_0000) begin
            next_wrAddr = 8'hff;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= CBR_HRESP_OKAY;
        end else if (clkEn) begin
            wrPend <= next_wrPend;
            wrAddr <= next_wrAddr;
            hrdata <= next_hrdata;
            hreadyout <= next_hreadyout;
            hresp <= next_hresp;
        end
    end

    // Rate selection. The wait state lets the non-volatile inputs settle after reset
    // before the one and only power-on decision is taken.
    always_comb begin
        next_state = state;
        next_source = source;
        next_canRate = canRate;
        next_rateReady = rateReady;
        next_saveStrobe = 1'b0;
        next_saveCode = saveCode;
        next_keptValid = keptValid;
        next_keptCode = keptCode;
        unique case (state)
            CBR_ST_WAIT: begin
                next_keptValid = keptInValid;
                next_keptCode = keptInCode;
                next_state = CBR_ST_EVAL;
            end
            CBR_ST_EVAL: begin
                next_canRate = pickRate;
                next_source = pickSource;
                next_rateReady = 1'b1;
                next_saveStrobe = 1'b1;
                next_saveCode = pickRate;
                if (cfgValid && cfgOverride) begin
                    // A valid overriding table becomes the newest retained value.
                    next_keptValid = 1'b1;
                    next_keptCode = pickRate;
                end
                next_state = CBR_ST_RUN;
            end
            CBR_ST_RUN: begin
                // The protocol engine wins over a software write in the same cycle.
                if (lssStrobe) begin
                    next_canRate = lssCode;
                    next_keptValid = 1'b1;
                    next_keptCode = lssCode;
                    next_saveStrobe = 1'b1;
                    next_saveCode = lssCode;
                    next_source = CBR_SRC_LSS;
                end else if (swWrite && hwdata[CBR_KEPT_VALID_BIT]) begin
                    next_canRate = hwdata[CBR_KEPT_CODE_LSB +: 2];
                    next_keptValid = 1'b1;
                    next_keptCode = hwdata[CBR_KEPT_CODE_LSB +: 2];
                    next_saveStrobe = 1'b1;
                    next_saveCode = hwdata[CBR_KEPT_CODE_LSB +: 2];
                    next_source = CBR_SRC_LSS;
                end
            end
            default: begin
                next_state = CBR_ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= CBR_ST_WAIT;
            source <= CBR_SRC_NONE;
            canRate <= CBR_RST_RATE;
            rateReady <= 1'b0;
            saveStrobe <= 1'b0;
            saveCode <= CBR_RST_RATE;
            keptValid <= 1'b0;
            keptCode <= CBR_RST_RATE;
        end else if (clkEn) begin
            state <= next_state;
            source <= next_source;
            canRate <= next_canRate;
            rateReady <= next_rateReady;
            saveStrobe <= next_saveStrobe;
            saveCode <= next_saveCode;
            keptValid <= next_keptValid;
            keptCode <= next_keptCode;
        end
    end

    default clocking cbr_cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic evalNow;
    logic runNow;
    logic tableWins;
    assign evalNow = (state == CBR_ST_EVAL) && clkEn;
    assign runNow = (state == CBR_ST_RUN) && clkEn;
    assign tableWins = cfgValid && cfgOverride;

    sequence s_lss_taken;
        runNow && lssStrobe;
    endsequence

    sequence s_saved(logic [1:0] code);
        saveStrobe && (saveCode == code) && (canRate == code);
    endsequence

    // Hardware updates win over software, so a write only counts without a strobe.
    sequence s_kept_taken;
        runNow && !lssStrobe && swWrite && hwdata[CBR_KEPT_VALID_BIT];
    endsequence

    a_override_apply: assert property (
        evalNow && tableWins |=> canRate == cbr_resolve($past(cfgCode)) && rateReady)
        else $error("override rate not applied");

    a_default_code: assert property (
        evalNow && tableWins && cfgCode >= CBR_CFG_FW_DEFAULT |=> canRate == CBR_RATE_500K)
        else $error("table default code did not give 500k");

    a_kept_apply: assert property (
        evalNow && !tableWins && keptValid |=> canRate == $past(keptCode))
        else $error("retained rate not applied");

    a_fallback: assert property (
        evalNow && !tableWins && !keptValid |=> canRate == CBR_RATE_FW_DEFAULT)
        else $error("firmware default not applied");

    a_lss_update: assert property (
        s_lss_taken |=> s_saved($past(lssCode)) ##0 keptValid && keptCode == canRate)
        else $error("layer-setting rate not taken");

    a_eval_save: assert property (
        evalNow |=> s_saved($past(pickRate)) ##1
            (!saveStrobe || $past(lssStrobe || swWrite || !clkEn)))
        else $error("power-on decision not saved once");

    a_eval_once: assert property (
        state == CBR_ST_RUN |=> state == CBR_ST_RUN && rateReady)
        else $error("rate decision repeated");

    a_rate_stable: assert property (
        runNow && !lssStrobe && !swWrite |=> $stable(canRate))
        else $error("rate changed without update");

    a_ready_legal: assert property (
        !rateReady |-> canRate == CBR_RST_RATE && !saveStrobe)
        else $error("rate driven before decision");

    // Checks on the software update path, the save pulse, the start-up capture and early updates, the clock enable and the rate source.
    a_kept_write: assert property (
        s_kept_taken |=> s_saved($past(hwdata[CBR_KEPT_CODE_LSB +: 2])) ##0 keptValid)
        else $error("retained rate write not applied");

    a_save_pulse: assert property (
        saveStrobe && clkEn && !(runNow && (lssStrobe || swWrite)) |=> !saveStrobe)
        else $error("save request longer than one cycle");

    a_wait_capture: assert property (
        state == CBR_ST_WAIT && clkEn
        |=> state == CBR_ST_EVAL && keptValid == $past(keptInValid)
            && keptCode == $past(keptInCode))
        else $error("retained rate not captured");

    a_source_kept: assert property (
        rateReady && source == CBR_SRC_KEPT |-> canRate == keptCode)
        else $error("retained source with other rate");

    a_hold_frozen: assert property (
        !clkEn |=> $stable(canRate) && $stable(state) && $stable(keptCode))
        else $error("state moved with clock enable low");

    a_early_ignored: assert property (
        evalNow && lssStrobe |=> canRate == $past(pickRate))
        else $error("early layer-setting rate applied");

    a_decided_src: assert property (
        rateReady |-> source != CBR_SRC_NONE)
        else $error("decision without a source");

endmodule
`default_nettype wire

/* File: tb/cbr_lss_master.sv */
`timescale 1ns/100ps
`default_nettype none
module cbr_lss_master (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Command from the bench
    input wire logic cmdGo,
    input wire logic [1:0] cmdCode,
    // Layer-setting update towards the device
    output logic lssStrobe,
    output logic [1:0] lssCode
);
    logic next_lssStrobe;
    logic [1:0] next_lssCode;

    always_comb begin
        next_lssStrobe = cmdGo;
        // Between commands the code lines toggle, so a stale code is never mistaken for a new one.
        next_lssCode = cmdGo ? cmdCode : ~lssCode;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lssStrobe <= 1'h0;
            lssCode <= 2'h0;
        end else begin
            lssStrobe <= next_lssStrobe;
            lssCode <= next_lssCode;
        end
    end
endmodule
`default_nettype wire

/* File: tb/can_bit_rate_power_on_select_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module can_bit_rate_power_on_select_tb;
    import cbr_pkg::*;
    typedef struct packed {
        logic v;
        logic o;
        logic [2:0] c;
        logic kv;
        logic [1:0] kc;
        logic [1:0] r;
    } cbr_row_type;
    // Table valid, override, table code, retained valid, retained code, expected rate.
    cbr_row_type rows [9] = '{
        '{1'h1, 1'h1, 3'h0, 1'h1, 2'h3, 2'h0},
        '{1'h1, 1'h1, 3'h1, 1'h0, 2'h0, 2'h1},
        '{1'h1, 1'h1, 3'h3, 1'h0, 2'h0, 2'h3},
        '{1'h1, 1'h1, 3'h4, 1'h1, 2'h1, 2'h2},
        '{1'h1, 1'h1, 3'h7, 1'h0, 2'h0, 2'h2},
        '{1'h1, 1'h0, 3'h0, 1'h1, 2'h1, 2'h1},
        '{1'h0, 1'h1, 3'h1, 1'h1, 2'h0, 2'h0},
        '{1'h0, 1'h0, 3'h0, 1'h0, 2'h0, 2'h2},
        '{1'h1, 1'h0, 3'h3, 1'h0, 2'h0, 2'h2}
    };
    logic core_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic clkEn = 1'h1;
    logic cfgValid = 1'h0;
    logic cfgOverride = 1'h0;
    logic [2:0] cfgCode = 3'h0;
    logic keptInValid = 1'h0;
    logic [1:0] keptInCode = 2'h0;
    logic cmdGo = 1'h0;
    logic [1:0] cmdCode = 2'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [31:0] hrdata;
    logic lssStrobe;
    logic saveStrobe;
    logic rateReady;
    logic hready;
    logic hresp;
    logic [1:0] lssCode;
    logic [1:0] canRate;
    logic [1:0] saveCode;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 core_clk = ~core_clk;

    cbr_lss_master master (.core_clk(core_clk), .sys_rst(sys_rst), .cmdGo(cmdGo),
        .cmdCode(cmdCode), .lssStrobe(lssStrobe), .lssCode(lssCode));

    cbr_rate_select dut (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .cfgValid(cfgValid), .cfgOverride(cfgOverride), .cfgCode(cfgCode),
        .keptInValid(keptInValid), .keptInCode(keptInCode), .lssStrobe(lssStrobe),
        .lssCode(lssCode), .canRate(canRate), .rateReady(rateReady),
        .saveStrobe(saveStrobe), .saveCode(saveCode), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp));

    task automatic conclude;
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One single word transfer; entered just after a rising edge.
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= CBR_HTRANS_NONSEQ;
        @(posedge core_clk);
        while (hready !== 1'h1) @(posedge core_clk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hready !== 1'h1) @(posedge core_clk);
        rd = hrdata;
    endtask

    task automatic start_run(input cbr_row_type r);
        @(posedge core_clk);
        sys_rst <= 1'h1;
        cfgValid <= r.v;
        cfgOverride <= r.o;
        cfgCode <= r.c;
        keptInValid <= r.kv;
        keptInCode <= r.kc;
        @(posedge core_clk);
        sys_rst <= 1'h0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // A hang is cut short well after the whole sequence should have ended.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        check(32'(canRate), 32'h2, "reset rate");
        check(32'({rateReady, hready, saveStrobe}), 32'h0, "reset flags");
        repeat (8) @(posedge core_clk);
        foreach (rows[i]) begin
            start_run(rows[i]);
            check(32'(canRate), 32'(rows[i].r), "rate");
            check(32'({rateReady, saveStrobe, saveCode}), 32'({3'h3, rows[i].r}), "save");
            @(posedge core_clk);
            ahb(1'h0, 32'(CBR_OFF_STATUS), 32'h0);
            check(rd & 32'h7, 32'({1'h1, rows[i].r}), "status");
            check(32'(hresp), 32'(CBR_HRESP_OKAY), "response");
            check(32'(saveStrobe), 32'h0, "save pulse");
        end
        // A layer-setting update before the decision is made must be ignored.
        @(posedge core_clk);
        sys_rst <= 1'h1;
        @(posedge core_clk);
        sys_rst <= 1'h0;
        cmdGo <= 1'h1;
        cmdCode <= 2'h1;
        @(posedge core_clk);
        cmdGo <= 1'h0;
        repeat (2) @(posedge core_clk);
        #1;
        check(32'({canRate, saveCode}), 32'ha, "early update");
        // Back-to-back updates in RUN.
        @(posedge core_clk);
        cmdGo <= 1'h1;
        @(posedge core_clk);
        cmdCode <= 2'h3;
        @(posedge core_clk);
        cmdGo <= 1'h0;
        #1;
        check(32'({canRate, saveStrobe, saveCode}), 32'hd, "update one");
        @(posedge core_clk);
        #1;
        check(32'({canRate, saveStrobe, saveCode}), 32'h1f, "update two");
        @(posedge core_clk);
        ahb(1'h0, 32'(CBR_OFF_STATUS), 32'h0);
        check(rd, 32'h67, "status after update");
        ahb(1'h0, 32'(CBR_OFF_KEPT), 32'h0);
        check(rd, 32'h7, "kept after update");
        ahb(1'h1, 32'(CBR_OFF_KEPT), 32'h4);
        #1;
        check(32'({canRate, saveStrobe}), 32'h1, "kept write");
        @(posedge core_clk);
        ahb(1'h1, 32'(CBR_OFF_KEPT), 32'h3);
        ahb(1'h1, 32'(CBR_OFF_STATUS), 32'h3);
        ahb(1'h0, 32'h8, 32'h0);
        check(rd, 32'h0, "unmapped");
        check(32'(hresp), 32'(CBR_HRESP_OKAY), "unmapped response");
        ahb(1'h0, 32'(CBR_OFF_KEPT), 32'h0);
        check(rd, 32'h4, "kept held");
        // With the clock enable low an update must not land.
        clkEn <= 1'h0;
        cmdGo <= 1'h1;
        cmdCode <= 2'h2;
        @(posedge core_clk);
        cmdGo <= 1'h0;
        repeat (2) @(posedge core_clk);
        clkEn <= 1'h1;
        @(posedge core_clk);
        #1;
        check(32'({canRate, saveStrobe}), 32'h0, "frozen");
        conclude();
    end
endmodule
`default_nettype wire
